// ===== verilog/external_bus_unit.v
// External bus unit: turns one internal request into an external memory cycle.
// Assumes a single requester on the system clock; external inputs are asynchronous.
// Summary of operation
// - Six active-low selects: boot region 32 Mbyte, five regions 16 Mbyte.
// - Each region has its own protection setting that refuses restricted accesses.
// - Boot region width comes from a reset strap; the other five region widths programmable.
// - Wait cycles are programmed separately for each region.
// - Burst accesses to burst flash keep the address still after the first.
// - Big-endian and little-endian byte ordering onto the data bus.
// - A select not enabled as select drives a programmable output level.
// - A 25-bit address bus is driven out.
// - 32-bit data bus: driven on writes, sampled from the device on reads.
// - Read/write output is high for reads and low for writes.
// - Output enable asserts only on reads, letting the device drive data.
// - Byte strobes mark active bytes; per region either on all cycles or writes.
// - Strobe zero governs the top data lane, strobe three the bottom lane.
// - A spare strobe may act as write strobe with assert and negate delays.
// - No output pulse is shorter than one system clock.
// - Top address byte 0x12 to 0x16 picks regions one to five when enabled.
// - Acknowledge on region five ends the cycle, else error after 1022 clocks.
// - Burst address load strobe asserts while a new start address is valid.
// - Burst terminate input reasserts the address load strobe and restarts the wait count; the address stays.
`timescale 1ns/1ps
`include "bus_unit_consts.vh"
module external_bus_unit #(
	parameter WAIT_W = 4,
	parameter TIMEOUT = `TIMEOUT_CLOCKS
) (
	input wire clock,
	input wire rst_n,
	input wire boot_port_strap,
	input wire [1:0] boot_port_alt,
	input wire req_valid,
	input wire req_write,
	input wire req_burst,
	input wire req_privileged,
	input wire [31:0] req_addr,
	input wire [31:0] req_wdata,
	input wire [3:0] req_bytes,
	input wire big_endian,
	input wire [5:0] region_select_active,
	input wire [5:0] region_protect,
	input wire [5:0] gp_level,
	input wire [11:0] region_port,
	input wire [6*WAIT_W-1:0] region_wait,
	input wire [5:0] strobe_write_only,
	input wire [23:0] region_write_strobe_lane,
	input wire [6*WAIT_W-1:0] strobe_assert_delay,
	input wire [6*WAIT_W-1:0] strobe_negate_delay,
	input wire ack_enable,
	input wire external_transfer_ack,
	input wire burst_terminate_n,
	input wire [31:0] data_in,
	output reg [31:0] data_out,
	output reg data_oe,
	output reg [`ADDR_W-1:0] addr_out,
	output reg boot_region_select_n,
	output reg [4:0] region_select_n,
	output reg read_write,
	output reg output_enable_n,
	output reg [3:0] byte_lane_strobe_n,
	output reg burst_address_load_n,
	output reg req_ready,
	output reg req_done,
	output reg req_error,
	output reg [31:0] req_rdata
);
	localparam IDLE = 4'b0001;
	localparam ACCESS = 4'b0010;
	localparam HOLD = 4'b0100;
	localparam FINISH = 4'b1000;

	// Region decode used for both the select outputs and the per-region setup lookup.
	function [6:0] decode;
		input [31:0] a;
		input [5:0] en;
		begin
			decode = 7'h00;
			if (a[`DEC_HI:`BOOT_DEC_LO] == `DEC_BOOT)
				decode = {1'b1, 6'h01};
			else if (a[`DEC_HI:`DEC_LO] >= `DEC_R1 && a[`DEC_HI:`DEC_LO] <= `DEC_R5)
				decode = {1'b1, 6'h01 << (a[`DEC_HI:`DEC_LO] - `DEC_R1 + 8'h01)};
			if ((decode[5:0] & en) == 6'h00)
				decode = 7'h00;
		end
	endfunction

	// Index of a one-hot region vector.
	function [2:0] index_of;
		input [5:0] v;
		integer i;
		begin
			index_of = 3'h0;
			for (i = 0; i < 6; i = i + 1)
				if (v[i])
					index_of = i[2:0];
		end
	endfunction

	reg [3:0] state_reg;
	reg [5:0] sel_reg;
	reg [WAIT_W-1:0] wait_reg;
	reg [WAIT_W-1:0] cnt_reg;
	reg [9:0] tmo_reg;
	reg write_reg;
	reg burst_reg;
	reg [3:0] lanes_reg;
	reg [1:0] boot_port_reg;
	reg boot_latched_reg;
	reg ack_s1_reg, ack_s2_reg, term_s1_reg, term_s2_reg;
	reg [31:0] din_s1_reg, din_s2_reg;
	reg [2:0] sidx_reg;

	wire [6:0] hit = decode(req_addr, region_select_active);
	wire [2:0] hidx = index_of(hit[5:0]);
	wire [1:0] hport = (hidx == 3'h0) ? boot_port_reg : region_port[2*hidx +: 2];
	// Endian swap reverses lane order so strobe zero always means the top lane.
	wire [3:0] lanes = big_endian ? req_bytes : {req_bytes[0], req_bytes[1],
		req_bytes[2], req_bytes[3]};
	wire [31:0] wdata = big_endian ? req_wdata : {req_wdata[7:0], req_wdata[15:8],
		req_wdata[23:16], req_wdata[31:24]};
	wire waited = (cnt_reg >= wait_reg);
	wire ack_mode = ack_enable && sidx_reg == `ACK_REGION;
	wire [WAIT_W-1:0] adly = strobe_assert_delay[WAIT_W*sidx_reg +: WAIT_W];
	wire [WAIT_W-1:0] ndly = strobe_negate_delay[WAIT_W*sidx_reg +: WAIT_W];
	wire [3:0] wlane = region_write_strobe_lane[4*sidx_reg +: 4];

	// Acknowledge, burst terminate and read data pass two flip-flops before any logic uses them.
	always @(posedge clock) begin
		ack_s1_reg <= external_transfer_ack;
		ack_s2_reg <= ack_s1_reg;
		term_s1_reg <= burst_terminate_n;
		term_s2_reg <= term_s1_reg;
		din_s1_reg <= data_in;
		din_s2_reg <= din_s1_reg;
	end

	// Access sequencer; every select output is a flop so pulses last a whole clock.
	always @(posedge clock) begin
		if (!rst_n) begin
			state_reg <= IDLE;
			sel_reg <= 6'h00;
			wait_reg <= {WAIT_W{1'b0}};
			cnt_reg <= {WAIT_W{1'b0}};
			tmo_reg <= 10'h000;
			write_reg <= 1'b0;
			burst_reg <= 1'b0;
			lanes_reg <= 4'h0;
			sidx_reg <= 3'h0;
			boot_port_reg <= `PORT_32;
			boot_latched_reg <= 1'b0;
			data_out <= 32'h00000000;
			data_oe <= 1'b0;
			addr_out <= {`ADDR_W{1'b0}};
			boot_region_select_n <= 1'b1;
			region_select_n <= 5'h1F;
			read_write <= 1'b1;
			output_enable_n <= 1'b1;
			byte_lane_strobe_n <= 4'hF;
			burst_address_load_n <= 1'b1;
			req_ready <= 1'b0;
			req_done <= 1'b0;
			req_error <= 1'b0;
			req_rdata <= 32'h00000000;
		end else begin
			// The strap is caught after reset release, never by the reset itself.
			if (!boot_latched_reg) begin
				boot_port_reg <= boot_port_strap ? boot_port_alt : `PORT_32;
				boot_latched_reg <= 1'b1;
			end
			req_done <= 1'b0;
			req_error <= 1'b0;
			case (state_reg)
				IDLE: begin
					req_ready <= boot_latched_reg;
					// Unused selects show their programmed level.
					boot_region_select_n <= region_select_active[0] ? 1'b1 : gp_level[0];
					region_select_n <= region_select_active[5:1] | gp_level[5:1];
					if (req_valid && req_ready) begin
						req_ready <= 1'b0;
						if (!hit[6] || (region_protect[hidx] && !req_privileged)) begin
							req_error <= 1'b1;
							req_done <= 1'b1;
						end else begin
							sel_reg <= hit[5:0];
							sidx_reg <= hidx;
							wait_reg <= region_wait[WAIT_W*hidx +: WAIT_W];
							cnt_reg <= {WAIT_W{1'b0}};
							tmo_reg <= 10'h000;
							write_reg <= req_write;
							burst_reg <= req_burst;
							lanes_reg <= (hport == `PORT_32) ? lanes :
								(hport == `PORT_16) ? {lanes[1:0], 2'b00} | {lanes[3:2], 2'b00}
								: 4'h8;
							addr_out <= req_addr[`ADDR_W-1:0];
							read_write <= !req_write;
							output_enable_n <= req_write;
							data_out <= wdata;
							data_oe <= req_write;
							burst_address_load_n <= !req_burst;
							// Disabled selects keep their general output level during the access.
							boot_region_select_n <= region_select_active[0] ? !hit[0] :
								gp_level[0];
							region_select_n <= ~(hit[5:1] & region_select_active[5:1]) &
								(region_select_active[5:1] | gp_level[5:1]);
							state_reg <= ACCESS;
						end
					end
				end
				ACCESS: begin
					cnt_reg <= cnt_reg + {{(WAIT_W-1){1'b0}}, 1'b1};
					burst_address_load_n <= 1'b1;
					// Strobes open after the assert delay; on writes the write strobe lane closes after the negate delay if it exceeds the assert delay.
					if ((write_reg || !strobe_write_only[sidx_reg]) && cnt_reg >= adly)
						byte_lane_strobe_n <= ~(lanes_reg | (write_reg ? wlane : 4'h0));
					if (write_reg && cnt_reg >= ndly && ndly > adly)
						byte_lane_strobe_n <= byte_lane_strobe_n | wlane;
					if (burst_reg && !term_s2_reg) begin
						burst_address_load_n <= 1'b0;
						cnt_reg <= {WAIT_W{1'b0}};
					end else if (ack_mode) begin
						tmo_reg <= tmo_reg + 10'h001;
						if (ack_s2_reg)
							state_reg <= HOLD;
						else if (tmo_reg == TIMEOUT[9:0] - 10'h001) begin
							req_error <= 1'b1;
							state_reg <= HOLD;
						end
					end else if (waited && cnt_reg >= `MIN_PULSE)
						state_reg <= HOLD;
				end
				HOLD: begin
					req_rdata <= big_endian ? din_s2_reg : {din_s2_reg[7:0],
						din_s2_reg[15:8], din_s2_reg[23:16], din_s2_reg[31:24]};
					byte_lane_strobe_n <= 4'hF;
					output_enable_n <= 1'b1;
					data_oe <= 1'b0;
					boot_region_select_n <= region_select_active[0] ? 1'b1 : gp_level[0];
					region_select_n <= region_select_active[5:1] | gp_level[5:1];
					state_reg <= FINISH;
				end
				FINISH: begin
					req_done <= 1'b1;
					read_write <= 1'b1;
					req_ready <= 1'b1;
					state_reg <= IDLE;
				end
				default: state_reg <= IDLE;
			endcase
		end
	end
endmodule // external_bus_unit

// ===== include/bus_unit_consts.vh
// Constants for the external bus unit: decode patterns, field positions, timing counts.
// Included by the design file by its bare name; definitions only.
`ifndef BUS_UNIT_CONSTS_VH
`define BUS_UNIT_CONSTS_VH
`define NUM_REGIONS 6
`define DEC_BOOT 7'h08
`define DEC_R1 8'h12
`define DEC_R5 8'h16
`define DEC_HI 31
`define DEC_LO 24
`define BOOT_DEC_LO 25
`define ADDR_W 25
`define TIMEOUT_CLOCKS 1022
`define ACK_REGION 5
`define PORT_8 2'h0
`define PORT_16 2'h1
`define PORT_32 2'h2
`define MIN_PULSE 1
`endif

// ===== verif/bus_unit_props.sv
// Checker for the pins of the external bus unit.
// Assumes it is bound into the unit and sees only its ports.
`timescale 1ns/1ps
module bus_unit_props #(parameter TIMEOUT = 1022) (
	input wire clock,
	input wire rst_n,
	input wire [5:0] region_select_active,
	input wire [5:0] gp_level,
	input wire data_oe,
	input wire [24:0] addr_out,
	input wire boot_region_select_n,
	input wire [4:0] region_select_n,
	input wire read_write,
	input wire output_enable_n
);
	// Selects that are low and enabled as selects; general outputs are left out.
	wire [5:0] live = ~{region_select_n, boot_region_select_n} & region_select_active;
	reg [11:0] held_reg;
	// Counts a held region five select, since a silent device would stall the bus.
	always @(posedge clock)
		held_reg <= (!rst_n || region_select_n[4]) ? 12'h000 : held_reg + 12'h001;
	default clocking @(posedge clock); endclocking
	default disable iff (!rst_n);
	sequence boot_held;
		!boot_region_select_n ##1 !boot_region_select_n;
	endsequence
	one_select_a: assert property ($countones(live) <= 1)
		else $error("two selects active");
	gp_level_a: assert property (($past(rst_n) && $stable(gp_level)) |->
		((region_select_n ^ gp_level[5:1]) & ~region_select_active[5:1]) == 5'h00)
		else $error("disabled select level wrong");
	oe_read_a: assert property (!output_enable_n |-> read_write && !data_oe)
		else $error("output enable on a write");
	write_drive_a: assert property (data_oe |-> !read_write && output_enable_n)
		else $error("data driven on a read");
	oe_pulse_a: assert property ($fell(output_enable_n) |=> !output_enable_n)
		else $error("short output enable");
	select_pulse_a: assert property ($fell(region_select_n[0]) |=> !region_select_n[0])
		else $error("short select");
	addr_stand_a: assert property (boot_held |-> $stable(addr_out))
		else $error("address moved in access");
	timeout_bound_a: assert property (held_reg <= TIMEOUT + 8)
		else $error("region five cycle never ended");
endmodule // bus_unit_props
bind external_bus_unit bus_unit_props #(.TIMEOUT(TIMEOUT)) props (.clock(clock), .rst_n(rst_n),
	.region_select_active(region_select_active), .gp_level(gp_level), .data_oe(data_oe),
	.addr_out(addr_out), .boot_region_select_n(boot_region_select_n),
	.region_select_n(region_select_n), .read_write(read_write),
	.output_enable_n(output_enable_n));

// ===== verif/ext_memory_model.sv
// Far side memory model: one word behind each select it is wired to.
// Assumes active-low selects, strobes and output enable from the unit.
`timescale 1ns/1ps
module ext_memory_model #(parameter ACK_DELAY = 3) (
	input wire clock,
	input wire [5:0] sel_n,
	input wire read_write,
	input wire output_enable_n,
	input wire [3:0] byte_lane_strobe_n,
	input wire [31:0] data_out,
	input wire data_oe,
	input wire ack_on,
	output wire [31:0] data_in,
	output wire external_transfer_ack,
	output wire burst_terminate_n
);
	reg [31:0] mem [0:5];
	reg [31:0] last_reg = 32'h00000000;
	reg [3:0] ack_cnt_reg = 4'h0;
	reg [2:0] idx;
	integer k;
	// Picks the selected word.
	always @* begin
		idx = 3'h0;
		for (k = 5; k >= 0; k = k - 1)
			if (!sel_n[k])
				idx = k[2:0];
	end
	// Strobe zero writes the top byte lane and strobe three the bottom one.
	always @(posedge clock) begin
		if (data_oe && !read_write && sel_n != 6'h3F)
			for (k = 0; k < 4; k = k + 1)
				if (!byte_lane_strobe_n[k])
					mem[idx][31-8*k -: 8] <= data_out[31-8*k -: 8];
		if (!output_enable_n)
			last_reg <= mem[idx];
		ack_cnt_reg <= sel_n[5] ? 4'h0 : ack_cnt_reg + {3'h0, ack_cnt_reg != 4'hF};
	end
	// Released lines show the inverse of the last word, so stale data cannot pass.
	assign data_in = !output_enable_n ? mem[idx] : ~last_reg;
	assign external_transfer_ack = ack_on && ack_cnt_reg >= ACK_DELAY;
	assign burst_terminate_n = 1'b1;
endmodule // ext_memory_model

// ===== verif/external_bus_unit_tb_top.sv
// Testbench: requests through the unit, checked against the memory model.
// Assumes the model answers on the pins; no register bus exists.
`timescale 1ns/1ps
module external_bus_unit_tb_top;
	reg clock = 1'b0, rst_n = 1'b0, req_valid = 1'b0, req_write = 1'b0, req_priv = 1'b0;
	reg ack_on = 1'b1, err;
	// Configuration levels are driven by the bench so scenarios can change them.
	reg burst = 1'b0, be = 1'b1, ack_en = 1'b1;
	reg [3:0] bytes = 4'hF;
	reg [5:0] act = 6'h2F, prot = 6'h04, gp = 6'h00, swo = 6'h01;
	reg [11:0] port = 12'hAAA;
	reg [23:0] waits = 24'h321012, no_dly = 24'h000000;
	reg [31:0] req_addr = 32'h00000000, req_wdata = 32'h00000000, rd;
	reg [7:0] tops [0:4];
	wire [31:0] data_out, data_in, req_rdata;
	wire [24:0] addr_out;
	wire [4:0] sel_n;
	wire [3:0] strobe_n;
	wire data_oe, boot_n, read_write, oe_n, ack, term_n, req_ready, req_done, req_error;
	integer errors = 0, tests_run = 0, i;
	always #2 clock = ~clock;
	// Region two is protected, region four is a general output at level zero.
	external_bus_unit #(.WAIT_W(4), .TIMEOUT(8)) dut (.clock(clock), .rst_n(rst_n),
		.boot_port_strap(1'b0), .boot_port_alt(2'h2), .req_valid(req_valid),
		.req_write(req_write), .req_burst(burst), .req_privileged(req_priv),
		.req_addr(req_addr), .req_wdata(req_wdata), .req_bytes(bytes), .big_endian(be),
		.region_select_active(act), .region_protect(prot), .gp_level(gp),
		.region_port(port), .region_wait(waits), .strobe_write_only(swo),
		.region_write_strobe_lane(24'h000000), .strobe_assert_delay(no_dly),
		.strobe_negate_delay(no_dly), .ack_enable(ack_en), .external_transfer_ack(ack),
		.burst_terminate_n(term_n), .data_in(data_in), .data_out(data_out),
		.data_oe(data_oe), .addr_out(addr_out), .boot_region_select_n(boot_n),
		.region_select_n(sel_n), .read_write(read_write), .output_enable_n(oe_n),
		.byte_lane_strobe_n(strobe_n), .burst_address_load_n(), .req_ready(req_ready),
		.req_done(req_done), .req_error(req_error), .req_rdata(req_rdata));
	// The general output of region four is not wired to the memory.
	ext_memory_model mem (.clock(clock), .sel_n({sel_n[4], 1'b1, sel_n[2:0], boot_n}),
		.read_write(read_write), .output_enable_n(oe_n), .byte_lane_strobe_n(strobe_n),
		.data_out(data_out), .data_oe(data_oe), .ack_on(ack_on), .data_in(data_in),
		.external_transfer_ack(ack), .burst_terminate_n(term_n));
	task check(input [31:0] seen, input [31:0] exp, input [8*9-1:0] what);
		begin
			tests_run = tests_run + 1;
			if (seen !== exp) begin
				errors = errors + 1;
				$display("wrong value %0s expected %h seen %h", what, exp, seen);
			end
		end
	endtask
	// One request, raised once ready and held for one clock, then a bounded wait for completion.
	task access(input w, input [31:0] a, input [31:0] d, input p);
		integer n;
		begin
			n = 0;
			err = 1'b0;
			while (req_ready !== 1'b1 && n < 100) begin
				@(posedge clock);
				n = n + 1;
			end
			req_valid <= 1'b1;
			req_write <= w;
			req_addr <= a;
			req_wdata <= d;
			req_priv <= p;
			@(posedge clock);
			req_valid <= 1'b0;
			// A time-out error pulses before done, so it is gathered over the whole wait.
			while (req_done !== 1'b1 && n < 200) begin
				@(posedge clock);
				n = n + 1;
				err = err | (req_error === 1'b1);
			end
			if (n >= 200)
				errors = errors + 1;
			rd = req_rdata;
			err = err | (req_error === 1'b1);
		end
	endtask
	task test_done;
		begin
			$display("comparisons %0d mismatches %0d", tests_run, errors);
			if (errors == 0 && tests_run > 0)
				$display("*** PASS ***");
			else
				$display("*** FAIL ***");
			$finish;
		end
	endtask
	// Watchdog: the tests need a few hundred cycles at most.
	initial begin
		#20000;
		errors = errors + 1;
		test_done;
	end
	// Main sequence.
	initial begin
		tops[0] = 8'h10;
		tops[1] = 8'h12;
		tops[2] = 8'h13;
		tops[3] = 8'h14;
		tops[4] = 8'h16;
		repeat (10) @(posedge clock);
		rst_n <= 1'b1;
		for (i = 0; i < 5; i = i + 1) begin
			access(1'b1, {tops[i], 24'h000010}, 32'hA5C30F96 ^ i, 1'b1);
			check(err, 1'b0, "wr err");
			access(1'b0, {tops[i], 24'h000010}, 32'h00000000, 1'b1);
			check(rd, 32'hA5C30F96 ^ i, "rd data");
		end
		$display("test regions done");
		access(1'b0, 32'h20000000, 32'h00000000, 1'b1);
		check(err, 1'b1, "unmapped");
		access(1'b1, 32'h15000000, 32'h00000000, 1'b1);
		check(err, 1'b1, "disabled");
		check(sel_n[3], 1'b0, "gp level");
		gp <= 6'h10;
		repeat (2) @(posedge clock);
		check(sel_n[3], 1'b1, "gp high");
		gp <= 6'h00;
		repeat (2) @(posedge clock);
		access(1'b0, 32'h13000010, 32'h00000000, 1'b0);
		check(err, 1'b1, "protected");
		$display("test refusals done");
		ack_on <= 1'b0;
		access(1'b0, 32'h16000010, 32'h00000000, 1'b1);
		check(err, 1'b1, "timeout");
		ack_on <= 1'b1;
		$display("test timeout done");
		test_done;
	end
endmodule // external_bus_unit_tb_top
